// ==== hw/msl_cfg.svh ====
`ifndef MSL_CFG_SVH
`define MSL_CFG_SVH

// clock rate and blink figures
`define MSL_CLK_HZ 50000000
`define MSL_FAST_HZ 4
`define MSL_SLOW_HZ 1
`define MSL_PD_MHZ 500
// blink half periods, power-down period and lit time, in cycles
`define MSL_FAST_HALF ((`MSL_CLK_HZ / `MSL_FAST_HZ) / 2)
`define MSL_SLOW_HALF ((`MSL_CLK_HZ / `MSL_SLOW_HZ) / 2)
`define MSL_PD_PERIOD ((`MSL_CLK_HZ / `MSL_PD_MHZ) * 1000)
`define MSL_PD_LIT (`MSL_PD_PERIOD / 8)
// i2c gpio extender addresses
`define MSL_I2C_ADDR_A 7'h20
`define MSL_I2C_ADDR_B 7'h21

`endif

// ==== hw/msl_pkg.sv ====
package msl_pkg;

    // indication modes, in falling priority except configured, which outranks both boot modes
    typedef enum logic [2:0] {
        MSL_MODE_STRAP_FAULT = 3'h0,
        MSL_MODE_SUPPLY = 3'h1,
        MSL_MODE_PDOWN = 3'h2,
        MSL_MODE_RESET = 3'h3,
        MSL_MODE_SPI = 3'h4,
        MSL_MODE_SD = 3'h5,
        MSL_MODE_CONF = 3'h6,
        MSL_MODE_IDLE = 3'h7
    } msl_mode_type;

endpackage

// ==== hw/msl_status_led_encoder.sv ====
// Behaviour
// [R1] supply missing or input low: user lamp off, red on, done lamp off
// [R2] supply missing: 3.3V rail off and processor held in power-on reset
// [R3] spi flash boot: user off, done lamp on, red blinks 4 Hz half duty
// [R4] sd card boot: user off, done lamp on, red blinks 1 Hz half duty
// [R5] configured: done lamp off, user follows pin seven, red blinks or user
// [R6] power enable low: user lamp on, red blinks 0.5 Hz one eighth lit
// [R7] power down with sequencing: every module supply switched off
// [R8] powered and external reset low: all three lamps lit
// [R9] strap high: converters forced on; pattern off, off, on shows fatal
// [R10] answer i2c addresses 0x20 and 0x21 as gpio extender
// [R11] user lamp routed from pin seven after power-up, processor may remap
// [R12] blink timing counts clocks; reset and power-down win over boot
`include "msl_cfg.svh"

module msl_status_led_encoder
    import msl_pkg::*;
#(
    parameter int FAST_HALF = `MSL_FAST_HALF,
    parameter int SLOW_HALF = `MSL_SLOW_HALF,
    parameter int PD_PERIOD = `MSL_PD_PERIOD
)
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // carrier pins and supply state
    input wire logic module_power_enable_in,
    input wire logic external_reset_n_in,
    input wire logic no_sequencing_strap_in,
    input wire logic supply_good_in,
    // boot and configuration progress
    input wire logic boot_spi_in,
    input wire logic boot_sd_in,
    input wire logic config_done_in,
    // processor pin and user drive of the lamps
    input wire logic processor_pin_seven_in,
    input wire logic user_lamp_sel_in,
    input wire logic user_lamp_value_in,
    input wire logic user_red_sel_in,
    input wire logic user_red_value_in,
    // decoded i2c address
    input wire logic [6:0] i2c_addr_in,
    input wire logic i2c_addr_valid_in,
    // lamps, high = lit
    output logic green_user_lamp_out,
    output logic red_status_lamp_out,
    output logic green_config_done_lamp_out,
    // power control
    output logic rail_3v3_enable_out,
    output logic processor_por_out,
    output logic supplies_enable_out,
    // status and i2c answer
    output logic fatal_error_out,
    output logic i2c_addr_ack_out,
    output logic [1:0] mode_out
);

    // lit span of the power-down period
    localparam int PD_LIT = PD_PERIOD / 8;

    // blink counters and phases, and the user lamp remap flag
    logic [31:0] fast_cnt_ff;
    logic fast_ff;
    logic [31:0] slow_cnt_ff;
    logic slow_ff;
    logic [31:0] pd_cnt_ff;
    logic pd_ff;
    logic remap_ff;
    // combinational mode and next lamp values
    msl_mode_type mode;
    logic nxt_user;
    logic nxt_red;
    logic nxt_done;

    // [R12] fast blink clock count
    // counters run from reset on, so every blink phase is known
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in || fast_cnt_ff == 32'(FAST_HALF - 1))
            fast_cnt_ff <= 32'h0;
        else
            fast_cnt_ff <= fast_cnt_ff + 32'h1;
    end

    // [R3] 4 hz square wave
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            fast_ff <= 1'b0;
        else if (fast_cnt_ff == 32'(FAST_HALF - 1))
            fast_ff <= ~fast_ff;
    end

    // [R12] slow blink clock count
    // a half second needs 25 bits; 32 keeps all three counters alike
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in || slow_cnt_ff == 32'(SLOW_HALF - 1))
            slow_cnt_ff <= 32'h0;
        else
            slow_cnt_ff <= slow_cnt_ff + 32'h1;
    end

    // [R4] 1 hz square wave
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            slow_ff <= 1'b0;
        else if (slow_cnt_ff == 32'(SLOW_HALF - 1))
            slow_ff <= ~slow_ff;
    end

    // [R6] 2 s period, lit for the first eighth
    // the full-rate period is 100 million cycles, well inside 32 bits
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in || pd_cnt_ff == 32'(PD_PERIOD - 1))
            pd_cnt_ff <= 32'h0;
        else
            pd_cnt_ff <= pd_cnt_ff + 32'h1;
    end

    // lit flag registered once more, so red lags the count by two cycles
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            pd_ff <= 1'b0;
        else
            pd_ff <= (pd_cnt_ff < 32'(PD_LIT));
    end

    // [R11] remap latched only once the processor runs out of reset
    // cleared on supply loss, so a fresh power-up shows pin seven again
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in || !supply_good_in || !module_power_enable_in)
            remap_ff <= 1'b0;
        else if (external_reset_n_in)
            remap_ff <= user_lamp_sel_in;
    end

    // [R12] priority: strap fault, supply, power-down, reset, configured, boot
    // power and reset faults win, so a stuck boot never hides them
    always_comb
    begin
        if (no_sequencing_strap_in && !supply_good_in)
            mode = MSL_MODE_STRAP_FAULT;
        else if (!supply_good_in)
            mode = MSL_MODE_SUPPLY;
        else if (!module_power_enable_in)
            mode = MSL_MODE_PDOWN;
        else if (!external_reset_n_in)
            mode = MSL_MODE_RESET;
        else if (config_done_in)
            mode = MSL_MODE_CONF;
        else if (boot_spi_in)
            mode = MSL_MODE_SPI;
        else if (boot_sd_in)
            mode = MSL_MODE_SD;
        else
            mode = MSL_MODE_IDLE;
    end

    // lamp pattern per mode
    // defaults keep every lamp dark unless a decoded case drives it
    always_comb
    begin
        nxt_user = 1'b0;
        nxt_red = 1'b0;
        nxt_done = 1'b0;
        case (mode)
            // [R9] fatal pattern
            MSL_MODE_STRAP_FAULT:
            begin
                nxt_done = 1'b1;
            end
            // [R1] supply missing
            MSL_MODE_SUPPLY:
            begin
                nxt_red = 1'b1;
            end
            // [R6] power-down blink
            MSL_MODE_PDOWN:
            begin
                nxt_user = 1'b1;
                nxt_red = pd_ff;
            end
            // [R8] all lamps lit
            MSL_MODE_RESET:
            begin
                nxt_user = 1'b1;
                nxt_red = 1'b1;
                nxt_done = 1'b1;
            end
            // [R3] spi boot
            MSL_MODE_SPI:
            begin
                nxt_red = fast_ff;
                nxt_done = 1'b1;
            end
            // [R4] sd boot
            MSL_MODE_SD:
            begin
                nxt_red = slow_ff;
                nxt_done = 1'b1;
            end
            // [R5] configured, done lamp dark
            MSL_MODE_CONF:
            begin
                nxt_user = remap_ff ? user_lamp_value_in : processor_pin_seven_in;
                nxt_red = user_red_sel_in ? user_red_value_in : slow_ff;
            end
            // powered but not yet booting: pin seven shown, unconfigured
            MSL_MODE_IDLE:
            begin
                nxt_user = processor_pin_seven_in;
                nxt_done = 1'b1;
            end
            // unreachable, all eight codes decoded; red lit as a safe mark
            default:
            begin
                nxt_red = 1'b1;
            end
        endcase
    end

    // lamp registers
    // red lit in reset: it needs no processor, so it shows life first
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            green_user_lamp_out <= 1'b0;
            red_status_lamp_out <= 1'b1;
            green_config_done_lamp_out <= 1'b0;
        end
        else
        begin
            green_user_lamp_out <= nxt_user;
            red_status_lamp_out <= nxt_red;
            green_config_done_lamp_out <= nxt_done;
        end
    end

    // [R2] rail stays off while supply or power enable is missing
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            rail_3v3_enable_out <= 1'b0;
        else
            rail_3v3_enable_out <= supply_good_in && module_power_enable_in;
    end

    // [R2] processor held in power-on reset; safe state on reset
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            processor_por_out <= 1'b1;
        else
            processor_por_out <= !supply_good_in || !module_power_enable_in
                || !external_reset_n_in;
    end

    // [R7] supplies off in power-down; [R9] strap forces converters on
    // the strap overrides sequencing, converters then run whatever we decide
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            supplies_enable_out <= 1'b0;
        else
            supplies_enable_out <= no_sequencing_strap_in
                || (supply_good_in && module_power_enable_in);
    end

    // [R9] fatal carrier error flag
    // the lamp pattern alone is easy to misread, the flag is not
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            fatal_error_out <= 1'b0;
        else
            fatal_error_out <= (mode == MSL_MODE_STRAP_FAULT);
    end

    // [R10] address match for both extender addresses
    // the two addresses differ only in the lowest bit
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            i2c_addr_ack_out <= 1'b0;
        else
            i2c_addr_ack_out <= i2c_addr_valid_in
                && (i2c_addr_in == `MSL_I2C_ADDR_A || i2c_addr_in == `MSL_I2C_ADDR_B);
    end

    // [R10] which extender is addressed; follows the address bus, not the qualifier
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            mode_out <= 2'h0;
        else
            mode_out <= {1'b0, i2c_addr_in == `MSL_I2C_ADDR_B};
    end

endmodule

// ==== verification/msl_carrier_model.sv ====
module msl_carrier_model (
    input wire logic [2:0] cmd_in,
    output logic power_enable_out,
    output logic reset_n_out,
    output logic strap_out,
    output logic good_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // 1 supply loss, 2 strap fault, 3 power down, 4 reset held, else running
    always_comb
    begin
        good_out = cmd_in != 3'h1 && cmd_in != 3'h2;
        strap_out = cmd_in == 3'h2;
        power_enable_out = cmd_in != 3'h3;
        reset_n_out = cmd_in != 3'h4;
    end
endmodule

// ==== verification/msl_chk.sv ====
module msl_chk (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic supply_good_in,
    input wire logic no_sequencing_strap_in,
    input wire logic module_power_enable_in,
    input wire logic external_reset_n_in,
    input wire logic boot_spi_in,
    input wire logic config_done_in,
    input wire logic i2c_addr_valid_in,
    input wire logic [6:0] i2c_addr_in,
    input wire logic green_user_lamp_out,
    input wire logic red_status_lamp_out,
    input wire logic green_config_done_lamp_out,
    input wire logic i2c_addr_ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic g, s, run, hit, lv_ff;
    logic [2:0] lp;
    // short names; lamps packed as user, red, done
    assign g = supply_good_in;
    assign s = no_sequencing_strap_in;
    assign run = g && module_power_enable_in && external_reset_n_in;
    assign hit = i2c_addr_valid_in && i2c_addr_in[6:1] == 6'h10;
    assign lp = {green_user_lamp_out, red_status_lamp_out, green_config_done_lamp_out};
    // outputs lag one edge, so the edge right after reset has no cause to check
    always_ff @(posedge ref_clk_in) lv_ff <= !reset_in;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_hit; hit; endsequence
    property p_nog; lv_ff && $past(!g && !s) |-> lp == 3'h2; endproperty
    a_nog: assert property (p_nog) else $error("supply loss lamps");
    property p_flt; lv_ff && $past(!g && s) |-> lp == 3'h1; endproperty
    a_flt: assert property (p_flt) else $error("strap fault lamps");
    property p_pd; lv_ff && $past(g && !module_power_enable_in) |-> lp[2]; endproperty
    a_pd: assert property (p_pd) else $error("power down lamp");
    property p_rs; lv_ff && $past(g && module_power_enable_in && !external_reset_n_in)
        |-> lp == 3'h7; endproperty
    a_rs: assert property (p_rs) else $error("reset lamps");
    property p_spi; lv_ff && $past(run && boot_spi_in && !config_done_in) |-> !lp[2] && lp[0];
    endproperty
    a_spi: assert property (p_spi) else $error("spi boot lamps");
    property p_cfg; lv_ff && $past(run && config_done_in) |-> !lp[0]; endproperty
    a_cfg: assert property (p_cfg) else $error("done lamp lit");
    property p_hit; s_hit |=> i2c_addr_ack_out; endproperty
    a_hit: assert property (p_hit) else $error("address not answered");
    property p_miss; !hit |=> !i2c_addr_ack_out; endproperty
    a_miss: assert property (p_miss) else $error("stray answer");
endmodule

bind msl_status_led_encoder msl_chk chk (.ref_clk_in, .reset_in, .supply_good_in,
    .no_sequencing_strap_in, .module_power_enable_in, .external_reset_n_in, .boot_spi_in,
    .config_done_in, .i2c_addr_valid_in, .i2c_addr_in, .green_user_lamp_out,
    .red_status_lamp_out, .green_config_done_lamp_out, .i2c_addr_ack_out);

// ==== verification/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, spi = 0, sd = 0, cfg = 0, p7 = 0, ls = 0, rs = 0, v = 0;
    logic [6:0] a = 7'h00;
    logic [2:0] c = 3'h0;
    logic pe, rn, st, gd, u, r, d, rl, por, sup, ft, ak;
    logic [1:0] mo;
    int err_total = 0, n_tests = 0, cy = 0;
    msl_carrier_model m (.cmd_in(c), .power_enable_out(pe), .reset_n_out(rn), .strap_out(st),
        .good_out(gd));
    // short blink counts keep the run brief; user values follow the inverse of pin seven
    msl_status_led_encoder #(.FAST_HALF(4), .SLOW_HALF(16), .PD_PERIOD(64)) dut (
        .ref_clk_in(clk), .reset_in(rst), .module_power_enable_in(pe),
        .external_reset_n_in(rn), .no_sequencing_strap_in(st), .supply_good_in(gd),
        .boot_spi_in(spi), .boot_sd_in(sd), .config_done_in(cfg),
        .processor_pin_seven_in(p7), .user_lamp_sel_in(ls), .user_lamp_value_in(!p7),
        .user_red_sel_in(rs), .user_red_value_in(!p7), .i2c_addr_in(a),
        .i2c_addr_valid_in(v), .green_user_lamp_out(u), .red_status_lamp_out(r),
        .green_config_done_lamp_out(d), .rail_3v3_enable_out(rl), .processor_por_out(por),
        .supplies_enable_out(sup), .fatal_error_out(ft), .i2c_addr_ack_out(ak), .mode_out(mo));
    initial forever #10 clk = ~clk;
    // hang guard, far above the 480 or so cycles the tests need
    always @(posedge clk)
    begin
        cy++;
        if (cy == 5000)
        begin
            err_total++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic go(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // lit cycles and rising edges of red over whole periods
    task automatic blink(input int n, input logic [15:0] e);
        logic [7:0] h;
        logic [7:0] k;
        logic p;
        h = 8'h00;
        k = 8'h00;
        p = r;
        repeat (n)
        begin
            go(1);
            h += r;
            k += r & !p;
            p = r;
        end
        cmp({h, k}, e);
    endtask
    task automatic t_boot();
        p7 = 1;
        go(2);
        cmp({u, r, d, rl, por, sup}, 6'h2d);
        spi = 1;
        go(2);
        cmp({u, d}, 2'h1);
        blink(64, 16'h2008);
        spi = 0;
        sd = 1;
        go(2);
        cmp({u, d}, 2'h1);
        blink(128, 16'h4004);
        $display("boot test done");
    endtask
    task automatic t_conf();
        cfg = 1;
        go(2);
        cmp({u, d}, 2'h2);
        blink(128, 16'h4004);
        ls = 1;
        rs = 1;
        go(2);
        cmp({u, r, d}, 3'h0);
        p7 = 0;
        go(2);
        cmp({u, r}, 2'h3);
        rs = 0;
        $display("config test done");
    endtask
    // boot and config stay up underneath, so every fault must win over them
    task automatic t_power();
        c = 3'h1;
        go(2);
        cmp({u, r, d, rl, por}, 5'h09);
        c = 3'h2;
        go(2);
        cmp({u, r, d, ft, sup}, 5'h07);
        c = 3'h4;
        go(2);
        cmp({u, r, d}, 3'h7);
        c = 3'h3;
        go(2);
        cmp({u, sup}, 2'h2);
        blink(128, 16'h1002);
        c = 3'h0;
        $display("power test done");
    endtask
    // neighbours of the pair get no answer; mode shows whether 0x21 is on the bus
    task automatic t_i2c();
        for (int i = 0; i < 4; i++)
        begin
            a = 7'h1f + 7'(i);
            v = 1;
            go(1);
            v = 0;
            cmp({ak, mo}, 12'h160 >> (3 * i) & 12'h007);
            go(1);
        end
        $display("i2c test done");
    endtask
    initial
    begin
        go(4);
        rst = 0;
        t_boot();
        t_conf();
        t_power();
        t_i2c();
        results();
    end
endmodule
